/* File: inc/atf_cfg.svh */
`ifndef ATF_CFG_SVH
`define ATF_CFG_SVH

// ----------------------------------------
// Register addresses {cs1, cs0, da[2:0]}
// ----------------------------------------
// Chip selects taken as asserted-high here
`define ATF_A_DATA 5'h08
`define ATF_A_ERRFEAT 5'h09
`define ATF_A_COUNT 5'h0A
`define ATF_A_LBALO 5'h0B
`define ATF_A_DEVHEAD 5'h0E
`define ATF_A_CMD 5'h0F
`define ATF_A_DEVCTL 5'h16

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ATF_DC_HOB 7
`define ATF_DC_SRST 2
`define ATF_DC_NIEN 1
`define ATF_DH_DEV 4
`define ATF_DH_OBS_HI 7
`define ATF_DH_OBS_LO 5
`define ATF_ER_ABRT 2

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define ATF_RST_BYTE 8'h00
`define ATF_DIAG_DEFAULT 8'h01
`define ATF_DEV_RESET_CMD 8'h08
`define ATF_CLK_NS 8
`define ATF_SRST_DIAG_NS 2000
`define ATF_SRST_DIAG_CYC ((`ATF_SRST_DIAG_NS + `ATF_CLK_NS - 1) / `ATF_CLK_NS)

`endif

/* File: inc/atf_pkg.sv */
package atf_pkg;

    // Register targets decoded from the bus
    typedef enum logic [2:0] {
        ATF_REG_NONE = 3'b000,
        ATF_REG_DEVCTL = 3'b001,
        ATF_REG_DEVHEAD = 3'b010,
        ATF_REG_ERRFEAT = 3'b011,
        ATF_REG_COUNT = 3'b100,
        ATF_REG_LBALO = 3'b101,
        ATF_REG_CMD = 3'b110,
        ATF_REG_OTHER_CB = 3'b111
    } atf_reg_t;

    // Sampled host pins
    typedef struct packed {
        logic cs1_n;
        logic cs0_n;
        logic [2:0] da;
        logic dior_n;
        logic diow_n;
        logic dmack_n;
        logic [15:0] dd;
    } atf_pins_t;

    // Parameters handed over on a command write
    typedef struct packed {
        logic [7:0] command;
        logic [7:0] features;
        logic [7:0] count;
        logic [7:0] lba_low;
        logic [7:0] devhead;
    } atf_param_t;

    // Result write-back from command execution
    typedef struct packed {
        logic valid;
        logic [7:0] count;
        logic [7:0] lba_low;
        logic [7:0] devhead;
    } atf_tf_t;

    // Software reset sequencer states
    typedef enum logic [1:0] {
        ATF_SR_IDLE = 2'b00,
        ATF_SR_HOLD = 2'b01,
        ATF_SR_WAIT = 2'b10
    } atf_sr_state_t;

endpackage

/* File: rtl/atf_pin_sync.sv */
`timescale 1ns/1ns
`include "atf_cfg.svh"

module atf_pin_sync #(
    parameter int W = 24
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    input wire logic [W-1:0] rst_val_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_q;

    // Three-stage pipe, first stage read only by second
    always_ff @(posedge clk_i) begin
        s1_q <= d_i;
        s2_q <= s1_q;
        s3_q <= s2_q;
    end

    // Bit changes only once stages two and three agree
    genvar i;
    for (i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                out_q[i] <= rst_val_i[i];
            end else if (s2_q[i] == s3_q[i]) begin
                out_q[i] <= s3_q[i];
            end
        end
    end

    assign q_o = out_q;
endmodule // atf_pin_sync

/* File: rtl/atf_srst_seq.sv */
`timescale 1ns/1ns
`include "atf_cfg.svh"

module atf_srst_seq #(
    parameter int DIAG_CYC = `ATF_SRST_DIAG_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic srst_i,
    output logic busy_o,
    output logic done_o
);
    import atf_pkg::*;

    atf_sr_state_t state_q;
    logic [15:0] cnt_q;
    logic done_q;

    // Hold while the bit is set, then time the diagnostic
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ATF_SR_IDLE;
            cnt_q <= 16'h0000;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            unique case (state_q)
                ATF_SR_IDLE: begin
                    if (start_i) begin
                        state_q <= ATF_SR_HOLD;
                    end
                end
                ATF_SR_HOLD: begin
                    cnt_q <= 16'h0000;
                    if (!srst_i) begin
                        state_q <= ATF_SR_WAIT;
                    end
                end
                ATF_SR_WAIT: begin
                    if (srst_i) begin
                        state_q <= ATF_SR_HOLD;
                    end else if (cnt_q == 16'(DIAG_CYC - 1)) begin
                        state_q <= ATF_SR_IDLE;
                        done_q <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                default: begin
                    state_q <= ATF_SR_IDLE;
                end
            endcase
        end
    end

    assign busy_o = (state_q != ATF_SR_IDLE);
    assign done_o = done_q;
endmodule // atf_srst_seq

/* File: rtl/atf_task_regs.sv */
`timescale 1ns/1ns
`include "atf_cfg.svh"


module atf_task_regs #(
    parameter logic DEV_ID = 1'b0,
    parameter logic PACKET_DEV = 1'b0,
    parameter logic [7:0] DIAG_CODE = `ATF_DIAG_DEFAULT,
    parameter logic [7:0] DEV_RESET_CMD = `ATF_DEV_RESET_CMD,
    parameter int SRST_DIAG_CYC = `ATF_SRST_DIAG_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cs0_n_i,
    input wire logic cs1_n_i,
    input wire logic [2:0] da_i,
    input wire logic dior_n_i,
    input wire logic diow_n_i,
    input wire logic dmack_n_i,
    input wire logic [15:0] dd_i,
    output logic [15:0] dd_o,
    output logic dd_oe_n_o,
    output logic intrq_o,
    output logic intrq_oe_n_o,
    input wire logic bsy_i,
    input wire logic drq_i,
    input wire logic sleep_i,
    input wire logic intr_pending_i,
    input wire logic [7:0] alt_status_i,
    input wire atf_pkg::atf_tf_t tf_wb_i,
    input wire logic err_load_i,
    input wire logic [7:0] err_code_i,
    input wire logic abort_i,
    input wire logic diag_load_i,
    input wire logic [7:0] diag_code_i,
    output logic cmd_valid_o,
    output atf_pkg::atf_param_t cmd_o,
    output logic err_clear_o,
    output logic sw_reset_o,
    output logic srst_busy_o,
    output logic dev_selected_o,
    output logic devhead_valid_o,
    output logic hob_o
);
    import atf_pkg::*;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    function automatic atf_reg_t decode(input atf_pins_t p);
        logic [4:0] a;
        a = {~p.cs1_n, ~p.cs0_n, p.da};
        unique case (a)
            `ATF_A_DEVCTL: decode = ATF_REG_DEVCTL;
            `ATF_A_DEVHEAD: decode = ATF_REG_DEVHEAD;
            `ATF_A_ERRFEAT: decode = ATF_REG_ERRFEAT;
            `ATF_A_COUNT: decode = ATF_REG_COUNT;
            `ATF_A_LBALO: decode = ATF_REG_LBALO;
            `ATF_A_CMD: decode = ATF_REG_CMD;
            default: begin
                // Remaining CS0 registers except data
                if (a[4:3] == 2'b01 && a != `ATF_A_DATA) begin
                    decode = ATF_REG_OTHER_CB;
                end else begin
                    decode = ATF_REG_NONE;
                end
            end
        endcase
    endfunction

    // ----------------------------------------
    // Pin sampling and strobe detection
    // ----------------------------------------
    atf_pins_t pins;
    atf_pins_t pins_raw;
    atf_pins_t pins_idle;
    logic diow_prev_q;
    logic wr_ev;
    logic rd_act;
    atf_reg_t wr_reg;
    atf_reg_t rd_reg;
    logic [7:0] wd;

    assign pins_raw = {cs1_n_i, cs0_n_i, da_i, dior_n_i, diow_n_i, dmack_n_i, dd_i};
    assign pins_idle = {1'b1, 1'b1, 3'h0, 1'b1, 1'b1, 1'b1, 16'h0000};

    atf_pin_sync #(
        .W($bits(atf_pins_t))
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(pins_raw),
        .rst_val_i(pins_idle),
        .q_o(pins)
    );

    // Write taken on the trailing edge of the write strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            diow_prev_q <= 1'b1;
        end else begin
            diow_prev_q <= pins.diow_n;
        end
    end

    assign wr_ev = pins.diow_n & ~diow_prev_q & pins.dmack_n;
    assign rd_act = ~pins.dior_n & pins.dmack_n;
    assign wr_reg = decode(pins);
    assign rd_reg = decode(pins);
    assign wd = pins.dd[7:0];

    // ----------------------------------------
    // Write qualification
    // ----------------------------------------
    logic [7:0] devhead_q;
    logic wr_dc;
    logic wr_cb_any;
    logic cb_ok;
    logic cmd_take;
    logic is_dev_reset;

    assign is_dev_reset = (wd == DEV_RESET_CMD);
    // Busy or sleeping device ignores command block writes; device reset command passes unless a non-packet device sleeps
    assign cb_ok = ~bsy_i & ~sleep_i;
    assign wr_dc = wr_ev & (wr_reg == ATF_REG_DEVCTL);
    assign wr_cb_any = wr_ev & (wr_reg != ATF_REG_NONE) & (wr_reg != ATF_REG_DEVCTL);
    assign cmd_take = wr_ev & (wr_reg == ATF_REG_CMD) & (devhead_q[`ATF_DH_DEV] == DEV_ID)
        & (cb_ok | (is_dev_reset & (~sleep_i | PACKET_DEV)));

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    logic hob_q;
    logic srst_q;
    logic nien_q;
    logic srst_start;

    // Start only on a zero-to-one write of the reset bit
    assign srst_start = wr_dc & wd[`ATF_DC_SRST] & ~srst_q;

    // Bits act on the write itself; bit 0 and reserved dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            srst_q <= 1'b0;
            nien_q <= 1'b0;
        end else if (wr_dc) begin
            srst_q <= wd[`ATF_DC_SRST];
            nien_q <= wd[`ATF_DC_NIEN];
        end
    end

    // High order byte select, cleared by any command block write except to the data register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hob_q <= 1'b0;
        end else if (wr_dc) begin
            hob_q <= wd[`ATF_DC_HOB];
        end else if (wr_cb_any) begin
            hob_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Software reset sequence
    // ----------------------------------------
    logic sr_done;

    atf_srst_seq #(
        .DIAG_CYC(SRST_DIAG_CYC)
    ) u_srst (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(srst_start),
        .srst_i(srst_q),
        .busy_o(srst_busy_o),
        .done_o(sr_done)
    );

    // ----------------------------------------
    // Drive select register
    // ----------------------------------------
    // Device bit live on write; signature clears it after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            devhead_q <= `ATF_RST_BYTE;
        end else if (sr_done) begin
            devhead_q[`ATF_DH_DEV] <= 1'b0;
        end else if (wr_ev & (wr_reg == ATF_REG_DEVHEAD) & cb_ok) begin
            devhead_q <= wd;
            devhead_q[`ATF_DH_OBS_HI] <= 1'b0;
            devhead_q[`ATF_DH_OBS_LO] <= 1'b0;
        end else if (tf_wb_i.valid & bsy_i) begin
            devhead_q <= tf_wb_i.devhead;
        end
    end

    // Contents kept through sleep only on packet devices
    assign devhead_valid_o = ~bsy_i & (~sleep_i | PACKET_DEV);
    assign dev_selected_o = (devhead_q[`ATF_DH_DEV] == DEV_ID);

    // ----------------------------------------
    // Features, count and address low
    // ----------------------------------------
    logic [7:0] feat_q;
    logic [7:0] count_q;
    logic [7:0] count_prev_q;
    logic [7:0] lba_q;
    logic [7:0] lba_prev_q;

    // Features written through the error address
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            feat_q <= `ATF_RST_BYTE;
        end else if (wr_ev & (wr_reg == ATF_REG_ERRFEAT) & cb_ok) begin
            feat_q <= wd;
        end
    end

    // Previous byte kept for high order readback
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_q <= `ATF_RST_BYTE;
            count_prev_q <= `ATF_RST_BYTE;
        end else if (wr_ev & (wr_reg == ATF_REG_COUNT) & cb_ok) begin
            count_q <= wd;
            count_prev_q <= count_q;
        end else if (tf_wb_i.valid & bsy_i) begin
            count_q <= tf_wb_i.count;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lba_q <= `ATF_RST_BYTE;
            lba_prev_q <= `ATF_RST_BYTE;
        end else if (wr_ev & (wr_reg == ATF_REG_LBALO) & cb_ok) begin
            lba_q <= wd;
            lba_prev_q <= lba_q;
        end else if (tf_wb_i.valid & bsy_i) begin
            lba_q <= tf_wb_i.lba_low;
        end
    end

    // ----------------------------------------
    // Error register
    // ----------------------------------------
    logic [7:0] error_q;
    logic dev_owns;

    // Error load and abort change error only while busy or requesting
    assign dev_owns = bsy_i | drq_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            error_q <= DIAG_CODE;
        end else if (sr_done) begin
            error_q <= DIAG_CODE;
        end else if (diag_load_i) begin
            error_q <= diag_code_i;
        end else if (err_load_i & dev_owns) begin
            error_q <= err_code_i;
            if (abort_i) begin
                error_q[`ATF_ER_ABRT] <= 1'b1;
            end
        end else if (abort_i & dev_owns) begin
            error_q[`ATF_ER_ABRT] <= 1'b1;
        end
    end

    // ----------------------------------------
    // Command capture
    // ----------------------------------------
    logic cmd_valid_q;
    atf_param_t cmd_q;
    logic err_clear_q;
    logic sw_reset_q;

    // Snapshot of the task file on the command write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_valid_q <= 1'b0;
            cmd_q <= '0;
        end else begin
            cmd_valid_q <= cmd_take;
            if (cmd_take) begin
                cmd_q.command <= wd;
                cmd_q.features <= feat_q;
                cmd_q.count <= count_q;
                cmd_q.lba_low <= lba_q;
                cmd_q.devhead <= devhead_q;
            end
        end
    end

    // Error flag clear and software reset pulses
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_clear_q <= 1'b1;
            sw_reset_q <= 1'b0;
        end else begin
            err_clear_q <= cmd_take | srst_start;
            sw_reset_q <= srst_start;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    logic [7:0] rd_d;
    logic rd_hit;
    logic [7:0] rd_q;
    logic rd_en_q;

    // Host read mux; control address answers with alternate status
    always_comb begin
        rd_d = 8'h00;
        rd_hit = 1'b1;
        unique case (rd_reg)
            ATF_REG_DEVCTL: rd_d = alt_status_i;
            ATF_REG_DEVHEAD: rd_d = devhead_q;
            ATF_REG_ERRFEAT: rd_d = error_q;
            ATF_REG_COUNT: rd_d = hob_q ? count_prev_q : count_q;
            ATF_REG_LBALO: rd_d = hob_q ? lba_prev_q : lba_q;
            ATF_REG_CMD, ATF_REG_OTHER_CB, ATF_REG_NONE: rd_hit = 1'b0;
        endcase
    end

    // Only the selected device answers reads
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_q <= 8'h00;
            rd_en_q <= 1'b0;
        end else begin
            rd_q <= rd_d;
            rd_en_q <= rd_act & rd_hit & dev_selected_o;
        end
    end

    assign dd_o = {8'h00, rd_q};
    assign dd_oe_n_o = ~rd_en_q;

    // ----------------------------------------
    // Interrupt pin
    // ----------------------------------------
    logic intrq_q;
    logic intrq_en_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            intrq_q <= 1'b0;
            intrq_en_q <= 1'b0;
        end else begin
            intrq_q <= intr_pending_i;
            intrq_en_q <= ~nien_q & dev_selected_o;
        end
    end

    assign intrq_o = intrq_q;
    assign intrq_oe_n_o = ~intrq_en_q;

    assign cmd_valid_o = cmd_valid_q;
    assign cmd_o = cmd_q;
    assign err_clear_o = err_clear_q;
    assign sw_reset_o = sw_reset_q;
    assign hob_o = hob_q;
endmodule // atf_task_regs

/* File: sim/atf_task_regs_monitor.sv */
`timescale 1ns/1ns

module atf_task_regs_monitor #(
    parameter logic DEV_ID = 1'b0,
    parameter logic PACKET_DEV = 1'b0,
    parameter logic [7:0] DEV_RESET_CMD = 8'h08
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic dior_n_i,
    input wire logic bsy_i,
    input wire logic sleep_i,
    input wire logic intr_pending_i,
    input wire logic [15:0] dd_o,
    input wire logic dd_oe_n_o,
    input wire logic intrq_o,
    input wire logic intrq_oe_n_o,
    input wire logic cmd_valid_o,
    input wire atf_pkg::atf_param_t cmd_o,
    input wire logic err_clear_o,
    input wire logic sw_reset_o,
    input wire logic srst_busy_o,
    input wire logic dev_selected_o,
    input wire logic devhead_valid_o
);
    import atf_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Clear pulse, then busy in the reset sequence
    sequence s_srst_go;
        err_clear_o ##1 srst_busy_o;
    endsequence

    a_intr_level: assert property (
        !$past(rst_i) |-> intrq_o == $past(intr_pending_i)) else $error("intrq level wrong");
    a_intr_float: assert property (
        !$past(rst_i) && !$past(dev_selected_o) |-> intrq_oe_n_o) else $error("intrq not floated");
    a_read_drive: assert property (
        !dd_oe_n_o |-> dd_o[15:8] == 8'h00 && dev_selected_o && !$past(dior_n_i, 5))
        else $error("data driven without own read");
    a_cmd_once: assert property (
        cmd_valid_o |=> !cmd_valid_o) else $error("command pulse too long");
    a_cmd_clear: assert property (
        cmd_valid_o |-> err_clear_o && $past(dev_selected_o)) else $error("command without clear");
    a_cmd_busy: assert property (
        cmd_valid_o && $past(bsy_i) |-> cmd_o.command == DEV_RESET_CMD)
        else $error("command taken while busy");
    a_cmd_hold: assert property (
        !$past(rst_i) && !cmd_valid_o |-> $stable(cmd_o)) else $error("parameters moved");
    a_srst_start: assert property (
        sw_reset_o |-> s_srst_go) else $error("soft reset sequence wrong");
    a_srst_sig: assert property (
        $fell(srst_busy_o) |=> dev_selected_o == !DEV_ID) else $error("signature select wrong");
    a_head_valid: assert property (
        devhead_valid_o == (!bsy_i && (!sleep_i || PACKET_DEV))) else $error("head valid wrong");
endmodule // atf_task_regs_monitor

bind atf_task_regs atf_task_regs_monitor #(
    .DEV_ID(DEV_ID), .PACKET_DEV(PACKET_DEV), .DEV_RESET_CMD(DEV_RESET_CMD)
) u_mon (
    .clk_i, .rst_i, .dior_n_i, .bsy_i, .sleep_i, .intr_pending_i, .dd_o, .dd_oe_n_o,
    .intrq_o, .intrq_oe_n_o, .cmd_valid_o, .cmd_o, .err_clear_o, .sw_reset_o,
    .srst_busy_o, .dev_selected_o, .devhead_valid_o
);

/* File: sim/atf_host_model.sv */
`timescale 1ns/1ns

module atf_host_model (
    input wire logic clock_i,
    input wire logic start_i,
    input wire logic rd_i,
    input wire logic [4:0] addr_i,
    input wire logic [7:0] wdat_i,
    input wire logic [15:0] dd_i,
    output atf_pkg::atf_pins_t pins_o,
    output logic [7:0] rdat_o,
    output logic done_o
);
    import atf_pkg::*;
    logic [4:0] cnt_q = 5'h00;

    // Idle bus at time zero
    initial begin
        pins_o = '1;
        rdat_o = 8'h00;
        done_o = 1'b0;
    end

    // Strobe low 8 cycles, gap 8 cycles, DMA never acknowledged
    always @(posedge clock_i) begin
        done_o <= 1'b0;
        pins_o.dmack_n <= 1'b1;
        if (cnt_q == 5'h00 && start_i) begin
            pins_o.cs1_n <= ~addr_i[4];
            pins_o.cs0_n <= ~addr_i[3];
            pins_o.da <= addr_i[2:0];
            pins_o.dior_n <= ~rd_i;
            pins_o.diow_n <= rd_i;
            pins_o.dd <= rd_i ? ~pins_o.dd : {8'h00, wdat_i};
            cnt_q <= 5'h01;
        end else if (cnt_q == 5'h08) begin
            rdat_o <= dd_i[7:0];
            pins_o.dior_n <= 1'b1;
            pins_o.diow_n <= 1'b1;
            cnt_q <= cnt_q + 5'h01;
        end else if (cnt_q == 5'h10) begin
            pins_o.cs1_n <= 1'b1;
            pins_o.cs0_n <= 1'b1;
            pins_o.da <= ~pins_o.da;
            pins_o.dd <= ~pins_o.dd; // Released lines show no old value
            done_o <= 1'b1;
            cnt_q <= 5'h00;
        end else if (cnt_q != 5'h00) begin
            cnt_q <= cnt_q + 5'h01;
        end
    end
endmodule // atf_host_model

/* File: sim/tb.sv */
`timescale 1ns/1ns
`include "atf_cfg.svh"

module tb;
    import atf_pkg::*;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic go = 1'b0, rd = 1'b0, bsy = 1'b0, slp = 1'b0, ip = 1'b0, el = 1'b0, ab = 1'b0;
    logic drq = 1'b0, dg = 1'b0;
    atf_tf_t tf = '0;
    logic [4:0] ad = 5'h00;
    logic [7:0] wd = 8'h00, ec = 8'h00, alt = 8'h00, hv, c;
    logic [15:0] dd_o, wire_dd;
    logic dd_oe_n, iq, iq_oe_n, cv, ecl, swr, sbz, sel, dv, hob, done, drv;
    atf_pins_t pins;
    atf_param_t cmd, cmd_seen;
    int n_errors = 0, checked = 0, n_cmd = 0, n_sw = 0, k;
    logic [7:0] m_dh = 8'h00, m_ft = 8'h00, m_err = 8'h01;
    logic [7:0] q_cnt[$] = '{8'h00, 8'h00}, q_lba[$] = '{8'h00, 8'h00};
    int m_hob = 0;

    always #4 clock_i = ~clock_i;
    assign wire_dd = dd_oe_n ? pins.dd : dd_o;

    atf_host_model hm (.clock_i(clock_i), .start_i(go), .rd_i(rd), .addr_i(ad), .wdat_i(wd),
        .dd_i(wire_dd), .pins_o(pins), .rdat_o(hv), .done_o(done));

    atf_task_regs #(.SRST_DIAG_CYC(4)) uut (.clk_i(clock_i), .rst_i(rst_i),
        .cs0_n_i(pins.cs0_n), .cs1_n_i(pins.cs1_n), .da_i(pins.da), .dior_n_i(pins.dior_n),
        .diow_n_i(pins.diow_n), .dmack_n_i(pins.dmack_n), .dd_i(wire_dd), .dd_o(dd_o),
        .dd_oe_n_o(dd_oe_n), .intrq_o(iq), .intrq_oe_n_o(iq_oe_n), .bsy_i(bsy), .drq_i(drq),
        .sleep_i(slp), .intr_pending_i(ip), .alt_status_i(alt), .tf_wb_i(tf),
        .err_load_i(el), .err_code_i(ec), .abort_i(ab), .diag_load_i(dg),
        .diag_code_i(alt), .cmd_valid_o(cv), .cmd_o(cmd), .err_clear_o(ecl),
        .sw_reset_o(swr), .srst_busy_o(sbz), .dev_selected_o(sel), .devhead_valid_o(dv),
        .hob_o(hob));

    // Pulse counters and drive tracker
    always @(posedge clock_i) begin
        if (cv === 1'b1) begin
            n_cmd++;
            cmd_seen = cmd;
        end
        if (swr === 1'b1) n_sw++;
        if (dd_oe_n === 1'b0) drv = 1'b1;
    end

    task automatic chk(input logic [39:0] g, input logic [39:0] e);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("Error at %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic bus(input logic r, input logic [4:0] a, input logic [7:0] v);
        int t;
        t = 0;
        go <= 1'b1;
        rd <= r;
        ad <= a;
        wd <= v;
        @(posedge clock_i);
        go <= 1'b0;
        while (done !== 1'b1 && t < 100) begin
            @(posedge clock_i);
            t++;
        end
        @(posedge clock_i);
    endtask

    // Host write plus model update
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        bus(1'b0, a, v);
        if (a == `ATF_A_DEVCTL) m_hob = v[7];
        else if (!bsy) begin
            m_hob = 0;
            case (a)
                `ATF_A_DEVHEAD: m_dh = v & 8'h5F;
                `ATF_A_ERRFEAT: m_ft = v;
                `ATF_A_COUNT: q_cnt.push_front(v);
                `ATF_A_LBALO: q_lba.push_front(v);
                default: ;
            endcase
        end
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
        bus(1'b1, a, 8'h00);
        chk(hv, e);
    endtask

    task automatic test_done;
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(37));
        repeat (16) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        rdchk(`ATF_A_ERRFEAT, 8'h01);
        rdchk(`ATF_A_DEVHEAD, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wr(`ATF_A_DEVHEAD, 8'($urandom) & 8'hEF);
            wr(`ATF_A_ERRFEAT, 8'($urandom));
            wr(`ATF_A_COUNT, 8'($urandom));
            wr(`ATF_A_LBALO, 8'($urandom));
            rdchk(`ATF_A_DEVHEAD, m_dh);
            rdchk(`ATF_A_LBALO, q_lba[0]);
            rdchk(`ATF_A_ERRFEAT, m_err);
            c = 8'($urandom);
            wr(`ATF_A_CMD, c);
            chk(cmd_seen, {c, m_ft, q_cnt[0], q_lba[0], m_dh});
        end
        $display("test registers done");
        wr(`ATF_A_DEVCTL, 8'h80);
        chk(hob, 1'b1);
        rdchk(`ATF_A_COUNT, q_cnt[m_hob]);
        c = 8'($urandom);
        alt <= c;
        rdchk(`ATF_A_DEVCTL, c);
        wr(`ATF_A_LBALO, 8'h3C);
        chk(hob, 1'b0);
        wr(`ATF_A_DEVHEAD, 8'h10);
        drv = 1'b0;
        wr(`ATF_A_DEVCTL, 8'h80);
        bus(1'b1, `ATF_A_COUNT, 8'h00);
        chk({sel, iq_oe_n, drv, hob}, 4'b0101);
        wr(`ATF_A_DEVHEAD, 8'h00);
        wr(`ATF_A_DEVCTL, 8'h02);
        chk({iq_oe_n, hob}, 2'b10);
        wr(`ATF_A_DEVCTL, 8'h00);
        ip <= 1'b1;
        repeat (2) @(posedge clock_i);
        chk({iq_oe_n, iq}, 2'b01);
        ip <= 1'b0;
        $display("test control done");
        bsy <= 1'b1;
        k = n_cmd;
        wr(`ATF_A_COUNT, 8'hA5);
        wr(`ATF_A_CMD, 8'h20);
        chk(n_cmd, k);
        ec <= 8'($urandom);
        el <= 1'b1;
        @(posedge clock_i);
        el <= 1'b0;
        ab <= 1'b1;
        m_err = ec | 8'h04;
        @(posedge clock_i);
        ab <= 1'b0;
        bsy <= 1'b0;
        rdchk(`ATF_A_COUNT, q_cnt[0]);
        rdchk(`ATF_A_ERRFEAT, m_err);
        bsy <= 1'b1;
        wr(`ATF_A_CMD, `ATF_DEV_RESET_CMD);
        chk(n_cmd, k + 1);
        // Write-back while busy, then error load under data request
        tf <= {1'b1, 8'hC3, 8'h96, 8'h00};
        ec <= ~ec;
        drq <= 1'b1;
        @(posedge clock_i);
        tf <= '0;
        bsy <= 1'b0;
        el <= 1'b1;
        @(posedge clock_i);
        el <= 1'b0;
        drq <= 1'b0;
        rdchk(`ATF_A_COUNT, 8'hC3);
        rdchk(`ATF_A_ERRFEAT, ec);
        dg <= 1'b1;
        @(posedge clock_i);
        dg <= 1'b0;
        rdchk(`ATF_A_ERRFEAT, alt);
        bsy <= 1'b0;
        $display("test busy done");
        wr(`ATF_A_DEVHEAD, 8'h10);
        slp <= 1'b1;
        k = n_sw;
        wr(`ATF_A_DEVCTL, 8'h04);
        chk({n_sw == k + 1, sbz, dv}, 3'b110);
        wr(`ATF_A_DEVCTL, 8'h00);
        slp <= 1'b0;
        repeat (8) @(posedge clock_i);
        chk({sbz, sel}, 2'b01);
        rdchk(`ATF_A_ERRFEAT, 8'h01);
        $display("test soft reset done");
        test_done;
    end

    // Watchdog, run needs about 950 cycles
    initial begin
        repeat (6000) @(posedge clock_i);
        n_errors++;
        test_done;
    end
endmodule // tb
